// ==== testbench/host_spi.sv ====
// host serial master model, mode 0, 24-bit frames
// assumes calls are made from sys_clk falling edges
module host_spi
#(
   parameter int HALF = 5
)
(
   input  wire logic sys_clk,
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_mosi,
   input  wire logic spi_miso_o,
   input  wire logic spi_miso_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic miso_pin;

   // ****
   // frame driver
   // ****
   // released line shows the inverse, never a stale level
   assign miso_pin = spi_miso_oe ? spi_miso_o : ~spi_miso_o;

   initial
   begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end

   task automatic frame(input logic [23:0] tx, output logic [15:0] rx);
      logic [23:0] sh;
      sh = 24'h00_0000;
      @(negedge sys_clk);
      spi_cs_n = 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         spi_mosi = tx[i];
         repeat (HALF) @(negedge sys_clk);
         spi_sclk = 1'b1;
         sh = {sh[22:0], miso_pin};
         repeat (HALF) @(negedge sys_clk);
         spi_sclk = 1'b0;
      end
      repeat (HALF) @(negedge sys_clk);
      spi_cs_n = 1'b1;
      repeat (HALF) @(negedge sys_clk);
      rx = sh[15:0];
   endtask : frame
endmodule : host_spi

// ==== testbench/seq_chk.sv ====
// concurrent checks on the sequencer outputs
// assumes it is bound to adc_logic_channel_sequencer
module seq_chk
   import seq_pkg::*;
#(
   parameter int DLY_CYC_14 = 20,
   parameter int CONV_12K   = 40,
   parameter int CONV_24K   = 30,
   parameter int CONV_6K    = 50,
   parameter int CONV_50    = 60,
   parameter int CONV_OTHER = 45
)
(
   input wire logic       sys_clk,
   input wire logic       nrst,
   input wire slot_cfg_t  active_cfg,
   input wire logic [3:0] active_slot,
   input wire logic       seq_busy,
   input wire logic       settle_phase,
   input wire logic       conv_phase,
   input wire logic       reading_done
);
   timeunit 1ns;
   timeprecision 1ps;
   int s_cnt_r;
   int s_cnt_nxt;
   int c_cnt_r;
   int c_cnt_nxt;
   int s_exp;
   int c_exp;
   logic [7:0] g_exp;

   always_comb
   begin
      s_cnt_nxt = (nrst && settle_phase) ? s_cnt_r + 1 : 0;
      c_cnt_nxt = (nrst && conv_phase) ? c_cnt_r + 1 : 0;
      case (active_cfg.preconversion_delay_code)
         DLY_CODE_11: s_exp = DLY_11_CYC;
         DLY_CODE_14: s_exp = DLY_CYC_14;
         default:     s_exp = int'(active_cfg.preconversion_delay_code) * DLY_STEP_CYC;
      endcase
      case (active_cfg.data_rate_code)
         RATE_CODE_12K: c_exp = CONV_12K;
         RATE_CODE_24K: c_exp = CONV_24K;
         RATE_CODE_6K:  c_exp = CONV_6K;
         RATE_CODE_50:  c_exp = CONV_50;
         default:       c_exp = CONV_OTHER;
      endcase
      case (active_cfg.gain_code)
         3'h0:    g_exp = 8'h02;
         3'h1:    g_exp = 8'h04;
         3'h4:    g_exp = 8'h14;
         3'h7:    g_exp = 8'ha0;
         default: g_exp = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      s_cnt_r <= s_cnt_nxt;
      c_cnt_r <= c_cnt_nxt;
   end

   // ****
   // assertions
   // ****
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   property p_settle_len;
      $fell(settle_phase) |-> s_cnt_r == $past(s_exp);
   endproperty
   a_settle_len: assert property (p_settle_len)
      else $error("settle length wrong");
   property p_conv_len;
      $fell(conv_phase) |-> c_cnt_r == $past(c_exp);
   endproperty
   a_conv_len: assert property (p_conv_len)
      else $error("conversion length wrong");
   property p_first_fixed;
      $rose(seq_busy) |-> !(settle_phase || conv_phase) ##1 !(settle_phase || conv_phase)
         ##1 (settle_phase || conv_phase);
   endproperty
   a_first_fixed: assert property (p_first_fixed)
      else $error("first reading overhead wrong");
   property p_no_refixed;
      $fell(conv_phase) && seq_busy |-> ##[0:1] (settle_phase || conv_phase);
   endproperty
   a_no_refixed: assert property (p_no_refixed)
      else $error("later reading has overhead");
   property p_done;
      reading_done |-> ($past(conv_phase) || $past(conv_phase, 2)) ##1 !reading_done;
   endproperty
   a_done: assert property (p_done)
      else $error("done pulse misplaced");
   property p_phase;
      (settle_phase || conv_phase) |-> seq_busy && !(settle_phase && conv_phase);
   endproperty
   a_phase: assert property (p_phase)
      else $error("phases overlap or run idle");
   property p_order;
      seq_busy && $past(seq_busy) && $changed(active_slot) |-> active_slot > $past(active_slot);
   endproperty
   a_order: assert property (p_order)
      else $error("slot order wrong");
   property p_gain;
      conv_phase |-> active_cfg.gain_tenths == g_exp;
   endproperty
   a_gain: assert property (p_gain)
      else $error("gain decode wrong");
   property p_filter;
      conv_phase && active_cfg.filter_type < 3'h2
         |-> active_cfg.filter == filter_sel_t'(active_cfg.filter_type[1:0]);
   endproperty
   a_filter: assert property (p_filter)
      else $error("filter decode wrong");
endmodule : seq_chk

bind adc_logic_channel_sequencer seq_chk #(
   .DLY_CYC_14(DLY_CYC_14),
   .CONV_12K(CONV_12K),
   .CONV_24K(CONV_24K),
   .CONV_6K(CONV_6K),
   .CONV_50(CONV_50),
   .CONV_OTHER(CONV_OTHER)
) u_seq_chk (
   .sys_clk(sys_clk),
   .nrst(nrst),
   .active_cfg(active_cfg),
   .active_slot(active_slot),
   .seq_busy(seq_busy),
   .settle_phase(settle_phase),
   .conv_phase(conv_phase),
   .reading_done(reading_done)
);

// ==== testbench/testbench.sv ====
// self-checking bench: slot registers and multichannel sequencing
// assumes seq_pkg, the design, seq_chk and host_spi are compiled first
module testbench
   import seq_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   localparam int D14 = 20;
   localparam int C12 = 40;
   localparam int C24 = 30;
   localparam int C6  = 50;
   localparam int C50 = 60;
   localparam int COT = 45;
   localparam logic [3:0]  SL[5] = '{4'h0, 4'h2, 4'h5, 4'h6, 4'h9};
   localparam logic [15:0] W0[5] = '{16'h1711, 16'h2731, 16'h7391, 16'h44f1, 16'h5a55};
   localparam logic [15:0] W1[5] = '{16'h0028, 16'h0018, 16'h1038, 16'h4071, 16'h004a};
   localparam logic [15:0] W2[5] = '{16'h3800, 16'h3800, 16'h3800, 16'h2c00, 16'h3800};
   localparam logic [7:0]  EG[5] = '{8'h02, 8'h04, 8'h14, 8'ha0, 8'h00};
   localparam filter_sel_t EF[5] = '{FILT_FOURTH_ORDER_SINC, FILT_FOURTH_ORDER_SINC, FILT_FOURTH_ORDER_SINC, FILT_FOURTH_ORDER_SINC_FIRST_ORDER_SINC,
                                     FILT_OTHER};
   localparam int ES[5] = '{D14, D14, D14, DLY_11_CYC, D14};
   localparam int EC[5] = '{C12, C24, C6, C50, COT};

   typedef struct packed {
      logic [3:0] slot;
      slot_cfg_t  cfg;
      int         f;
      int         s;
      int         c;
   } reading_t;

   logic       sys_clk;
   logic       nrst;
   logic       spi_sclk;
   logic       spi_cs_n;
   logic       spi_mosi;
   logic       spi_miso_o;
   logic       spi_miso_oe;
   slot_cfg_t  active_cfg;
   logic [3:0] active_slot;
   logic       seq_busy;
   logic       settle_phase;
   logic       conv_phase;
   logic       reading_done;
   reading_t   cur;
   reading_t   r;
   reading_t   rq[$];
   int         n_mismatch = 0;
   int         checked = 0;
   int         t;
   int         k;

   adc_logic_channel_sequencer #(.DLY_CYC_14(D14), .CONV_12K(C12), .CONV_24K(C24),
      .CONV_6K(C6), .CONV_50(C50), .CONV_OTHER(COT)) DUT (.sys_clk(sys_clk), .nrst(nrst),
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe), .active_cfg(active_cfg),
      .active_slot(active_slot), .seq_busy(seq_busy), .settle_phase(settle_phase),
      .conv_phase(conv_phase), .reading_done(reading_done));

   host_spi u_host (.sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe));

   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done

   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      logic [15:0] x;
      u_host.frame({1'b0, a, d}, x);
   endtask : wr

   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      logic [15:0] x;
      u_host.frame({1'b1, a, 16'h0000}, x);
      chk("rdata", 32'(e), 32'(x));
   endtask : rd

   // ****
   // reading monitor
   // ****
   always @(negedge sys_clk)
   begin
      if (!nrst)
         cur = '0;
      else
      begin
         if (reading_done)
         begin
            rq.push_back(cur);
            cur = '0;
         end
         if (conv_phase)
         begin
            cur.slot = active_slot;
            cur.cfg = active_cfg;
         end
         if (settle_phase)
            cur.s++;
         if (conv_phase)
            cur.c++;
         if (seq_busy && !settle_phase && !conv_phase && cur.s == 0 && cur.c == 0)
            cur.f++;
      end
   end

   // ****
   // stimulus
   // ****
   initial
   begin
      nrst = 1'b0;
      repeat (10) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (3) @(negedge sys_clk);
      rd(7'h0c, 16'h0000);
      for (k = 0; k < 3; k++)
         wr(7'h0c + 7'(k), 16'hffff);
      rd(7'h0c, 16'hffff);
      rd(7'h0d, 16'hffff);
      rd(7'h0e, 16'hff80);
      rd(7'h0f, 16'h0000);
      rd(7'h7f, 16'h0000);
      wr(ADDR_SEQ_CTRL, 16'h0001);
      repeat (10) @(negedge sys_clk);
      chk("busy_no_mask", 32'h0, 32'(seq_busy));
      for (k = 0; k < 5; k++)
      begin
         wr({1'b0, SL[k], WORD_ROUTE}, W0[k]);
         wr({1'b0, SL[k], WORD_RATE}, W1[k]);
         wr({1'b0, SL[k], WORD_DELAY}, W2[k]);
      end
      wr(ADDR_SEQ_MASK, 16'h0265);
      repeat (2)
      begin
         wr(ADDR_SEQ_CTRL, 16'h0001);
         chk("busy", 32'h1, 32'(seq_busy));
         t = 0;
         while (seq_busy !== 1'b0 && t < 20000)
         begin
            @(negedge sys_clk);
            t++;
         end
         if (t == 20000)
         begin
            n_mismatch++;
            test_done();
         end
      end
      rd(ADDR_SEQ_CTRL, 16'h0024);
      chk("readings", 32'd10, 32'(rq.size()));
      for (int i = 0; i < 10 && i < rq.size(); i++)
      begin
         k = i % 5;
         r = rq[i];
         chk("slot", 32'(SL[k]), 32'(r.slot));
         chk("pos_in", 32'(W0[k][15:12]), 32'(r.cfg.positive_input_select));
         chk("gain", 32'(EG[k]), 32'(r.cfg.gain_tenths));
         chk("cal_set", 32'(W1[k][15:12]), 32'(r.cfg.calibration_set_select));
         chk("rate", 32'(W1[k][7:3]), 32'(r.cfg.data_rate_code));
         chk("filter", 32'(EF[k]), 32'(r.cfg.filter));
         chk("delay_code", 32'(W2[k][15:10]), 32'(r.cfg.preconversion_delay_code));
         chk("fixed", (k == 0) ? 2 : 0, r.f);
         chk("settle", ES[k], r.s);
         chk("conv", EC[k], r.c);
      end
      test_done();
   end
endmodule : testbench

// ==== verilog/adc_logic_channel_sequencer.sv ====
// slot configuration store and multichannel reading sequencer
// assumes host writes over the serial port and honours the switching time in each delay
module adc_logic_channel_sequencer
   import seq_pkg::*;
#(
   parameter int DLY_CYC_14    = DLY_14_CYC,
   parameter int CONV_12K      = CONV_CYC_12K,
   parameter int CONV_24K      = CONV_CYC_24K,
   parameter int CONV_6K       = CONV_CYC_6K,
   parameter int CONV_50       = CONV_CYC_50,
   parameter int CONV_OTHER    = CONV_CYC_12K
)
(
   input  wire logic  sys_clk,
   input  wire logic  nrst,
   input  wire logic  spi_sclk,
   input  wire logic  spi_cs_n,
   input  wire logic  spi_mosi,
   output logic       spi_miso_o,
   output logic       spi_miso_oe,
   output slot_cfg_t  active_cfg,
   output logic [3:0] active_slot,
   output logic       seq_busy,
   output logic       settle_phase,
   output logic       conv_phase,
   output logic       reading_done
);

   // ****************************************
   // register port
   // ****************************************
   spi_req_t    req;
   logic        req_valid;
   logic [6:0]  rd_addr;
   logic [15:0] rd_data;

   spi_reg_port u_port (
      .sys_clk     (sys_clk),
      .nrst        (nrst),
      .spi_sclk    (spi_sclk),
      .spi_cs_n    (spi_cs_n),
      .spi_mosi    (spi_mosi),
      .spi_miso_o  (spi_miso_o),
      .spi_miso_oe (spi_miso_oe),
      .req         (req),
      .req_valid   (req_valid),
      .rd_addr     (rd_addr),
      .rd_data     (rd_data)
   );

   // ****************************************
   // slot store
   // ****************************************
   logic [15:0] route_r [NUM_SLOTS];
   logic [15:0] rate_r  [NUM_SLOTS];
   logic [15:0] delay_r [NUM_SLOTS];
   logic [15:0] route_nxt [NUM_SLOTS];
   logic [15:0] rate_nxt  [NUM_SLOTS];
   logic [15:0] delay_nxt [NUM_SLOTS];
   logic [15:0] mask_r, mask_nxt;
   logic        start;

   typedef enum {S_IDLE, S_FIXED, S_DELAY, S_CONV} seq_state_t;
   seq_state_t state_r, state_nxt;

   always_comb
   begin
      route_nxt = route_r;
      rate_nxt  = rate_r;
      delay_nxt = delay_r;
      mask_nxt  = mask_r;
      start     = 1'b0;
      if (req_valid && req.wr)
      begin
         if (!req.addr[6])
         begin
            case (req.addr[1:0])
               WORD_ROUTE: route_nxt[req.addr[5:2]] = req.wdata & MASK_ROUTE;
               WORD_RATE:  rate_nxt[req.addr[5:2]]  = req.wdata & MASK_RATE;
               WORD_DELAY: delay_nxt[req.addr[5:2]] = req.wdata & MASK_DELAY;
               default:    ;
            endcase
         end
         else if (req.addr == ADDR_SEQ_MASK)
            mask_nxt = req.wdata;
         else if (req.addr == ADDR_SEQ_CTRL)
            start = req.wdata[0];
      end
   end

   always_comb
   begin
      rd_data = 16'h0000;
      if (!rd_addr[6])
      begin
         case (rd_addr[1:0])
            WORD_ROUTE: rd_data = route_r[rd_addr[5:2]];
            WORD_RATE:  rd_data = rate_r[rd_addr[5:2]];
            WORD_DELAY: rd_data = delay_r[rd_addr[5:2]];
            default:    rd_data = 16'h0000;
         endcase
      end
      else if (rd_addr == ADDR_SEQ_MASK)
         rd_data = mask_r;
      else if (rd_addr == ADDR_SEQ_CTRL)
         rd_data = {10'h000, active_slot, 1'b0, seq_busy};
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < NUM_SLOTS; i++)
         begin
            route_r[i] <= CFG_RESET;
            rate_r[i]  <= CFG_RESET;
            delay_r[i] <= CFG_RESET;
         end
         mask_r <= 16'h0000;
      end
      else
      begin
         route_r <= route_nxt;
         rate_r  <= rate_nxt;
         delay_r <= delay_nxt;
         mask_r  <= mask_nxt;
      end
   end

   // ****************************************
   // timing lookups
   // ****************************************
   function automatic logic [23:0] delay_cyc(input logic [5:0] code);
      if (code == DLY_CODE_11)
         delay_cyc = 24'(DLY_11_CYC);
      else if (code == DLY_CODE_14)
         delay_cyc = 24'(DLY_CYC_14);
      else
         delay_cyc = 24'(code) * 24'(DLY_STEP_CYC);
   endfunction : delay_cyc

   function automatic logic [23:0] conv_cyc(input logic [4:0] code);
      case (code)
         RATE_CODE_12K: conv_cyc = 24'(CONV_12K);
         RATE_CODE_24K: conv_cyc = 24'(CONV_24K);
         RATE_CODE_6K:  conv_cyc = 24'(CONV_6K);
         RATE_CODE_50:  conv_cyc = 24'(CONV_50);
         default:       conv_cyc = 24'(CONV_OTHER);
      endcase
   endfunction : conv_cyc

   // lowest enabled slot strictly above 'from' (or from zero when first)
   function automatic logic [4:0] find_slot(input logic [15:0] m, input logic [3:0] from,
                                            input logic first);
      find_slot = 5'h10;
      for (int i = NUM_SLOTS - 1; i >= 0; i--)
         if (m[i] && (first || (i > int'(from))))
            find_slot = 5'(i);
   endfunction : find_slot

   // ****************************************
   // sequencer
   // ****************************************
   logic [23:0] cnt_r, cnt_nxt;
   logic [3:0]  slot_r, slot_nxt;
   slot_cfg_t   cfg_r, cfg_nxt;
   logic        done_r, done_nxt;
   logic [4:0]  pick;
   logic [23:0] dly;

   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      slot_nxt  = slot_r;
      cfg_nxt   = cfg_r;
      done_nxt  = 1'b0;
      pick      = find_slot(mask_r, slot_r, state_r == S_IDLE);
      dly       = delay_cyc(delay_r[pick[3:0]][15:10]);
      case (state_r)
         S_IDLE:
            if (start && !pick[4])
            begin
               slot_nxt  = pick[3:0];
               cfg_nxt   = cfg_from_words(route_r[pick[3:0]], rate_r[pick[3:0]],
                                          delay_r[pick[3:0]]);
               cnt_nxt   = 24'(FIXED_OVERHEAD_CYC - 1);
               state_nxt = S_FIXED;
            end
         S_FIXED:
            if (cnt_r == 24'h00_0000)
            begin
               cnt_nxt   = delay_cyc(cfg_r.preconversion_delay_code);
               state_nxt = (cnt_nxt == 24'h00_0000) ? S_CONV : S_DELAY;
               if (cnt_nxt == 24'h00_0000)
                  cnt_nxt = conv_cyc(cfg_r.data_rate_code) - 24'h00_0001;
               else
                  cnt_nxt = cnt_nxt - 24'h00_0001;
            end
            else
               cnt_nxt = cnt_r - 24'h00_0001;
         S_DELAY:
            if (cnt_r == 24'h00_0000)
            begin
               cnt_nxt   = conv_cyc(cfg_r.data_rate_code) - 24'h00_0001;
               state_nxt = S_CONV;
            end
            else
               cnt_nxt = cnt_r - 24'h00_0001;
         S_CONV:
            if (cnt_r == 24'h00_0000)
            begin
               done_nxt = 1'b1;
               if (pick[4])
                  state_nxt = S_IDLE;
               else
               begin
                  slot_nxt = pick[3:0];
                  cfg_nxt  = cfg_from_words(route_r[pick[3:0]], rate_r[pick[3:0]],
                                            delay_r[pick[3:0]]);
                  if (dly == 24'h00_0000)
                  begin
                     cnt_nxt   = conv_cyc(rate_r[pick[3:0]][7:3]) - 24'h00_0001;
                     state_nxt = S_CONV;
                  end
                  else
                  begin
                     cnt_nxt   = dly - 24'h00_0001;
                     state_nxt = S_DELAY;
                  end
               end
            end
            else
               cnt_nxt = cnt_r - 24'h00_0001;
         default:
            state_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         state_r <= S_IDLE;
         cnt_r   <= 24'h00_0000;
         slot_r  <= 4'h0;
         cfg_r   <= '0;
         done_r  <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         slot_r  <= slot_nxt;
         cfg_r   <= cfg_nxt;
         done_r  <= done_nxt;
      end
   end

   assign active_cfg   = cfg_r;
   assign active_slot  = slot_r;
   assign seq_busy     = (state_r != S_IDLE);
   assign settle_phase = (state_r == S_DELAY);
   assign conv_phase   = (state_r == S_CONV);
   assign reading_done = done_r;

endmodule : adc_logic_channel_sequencer

// ==== verilog/seq_pkg.sv ====
// constants, field layouts and carrier types for the logic-channel sequencer
// assumes a single 125 MHz system clock and a synchronous active-low reset
package seq_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int SYS_CLK_PERIOD_NS = 8;
   localparam int FIXED_OVERHEAD_CYC = 2;
   localparam int DLY_11_NS          = 16500;
   localparam int DLY_14_NS          = 33400;
   localparam int DLY_STEP_NS        = 1500;
   localparam int DLY_11_CYC   = (DLY_11_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
   localparam int DLY_14_CYC   = (DLY_14_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
   localparam int DLY_STEP_CYC = (DLY_STEP_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
   localparam int RATE_SPS_12K = 12000;
   localparam int RATE_SPS_24K = 24000;
   localparam int RATE_SPS_6K  = 6000;
   localparam int RATE_SPS_50  = 50;
   localparam int CONV_CYC_12K = 1_000_000_000 / (RATE_SPS_12K * SYS_CLK_PERIOD_NS);
   localparam int CONV_CYC_24K = 1_000_000_000 / (RATE_SPS_24K * SYS_CLK_PERIOD_NS);
   localparam int CONV_CYC_6K  = 1_000_000_000 / (RATE_SPS_6K * SYS_CLK_PERIOD_NS);
   localparam int CONV_CYC_50  = 1_000_000_000 / (RATE_SPS_50 * SYS_CLK_PERIOD_NS);

   // ****************************************
   // codes
   // ****************************************
   localparam logic [4:0] RATE_CODE_12K = 5'h05;
   localparam logic [4:0] RATE_CODE_24K = 5'h03;
   localparam logic [4:0] RATE_CODE_6K  = 5'h07;
   localparam logic [4:0] RATE_CODE_50  = 5'h0e;
   localparam logic [5:0] DLY_CODE_11   = 6'h0b;
   localparam logic [5:0] DLY_CODE_14   = 6'h0e;

   // ****************************************
   // register map and masks
   // ****************************************
   localparam int         NUM_SLOTS      = 16;
   localparam logic [1:0] WORD_ROUTE     = 2'h0;
   localparam logic [1:0] WORD_RATE      = 2'h1;
   localparam logic [1:0] WORD_DELAY     = 2'h2;
   localparam logic [6:0] ADDR_SEQ_MASK  = 7'h40;
   localparam logic [6:0] ADDR_SEQ_CTRL  = 7'h41;
   localparam logic [15:0] MASK_ROUTE    = 16'hffff;
   localparam logic [15:0] MASK_RATE     = 16'hffff;
   localparam logic [15:0] MASK_DELAY    = 16'hff80;
   localparam logic [15:0] CFG_RESET     = 16'h0000;
   localparam int SPI_FRAME_BITS = 24;
   localparam int SPI_CMD_BITS   = 8;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {FILT_FOURTH_ORDER_SINC, FILT_FOURTH_ORDER_SINC_FIRST_ORDER_SINC, FILT_OTHER} filter_sel_t;

   typedef struct packed {
      logic [3:0]  positive_input_select;
      logic [3:0]  negative_input_select;
      logic [2:0]  gain_code;
      logic        high_voltage_path_select;
      logic [2:0]  internal_signal_select;
      logic        tempco_correction_disable;
      logic [3:0]  calibration_set_select;
      logic [3:0]  alarm_threshold_select;
      logic [4:0]  data_rate_code;
      logic [2:0]  filter_type;
      logic [5:0]  preconversion_delay_code;
      logic        normal_settling_option;
      logic        filter_reset_option;
      logic        chopping_enable;
      logic [7:0]  gain_tenths;
      filter_sel_t filter;
   } slot_cfg_t;

   typedef struct packed {
      logic        wr;
      logic [6:0]  addr;
      logic [15:0] wdata;
   } spi_req_t;

   // gain in tenths; unlisted codes give zero
   function automatic logic [7:0] gain_tenths(input logic [2:0] code);
      case (code)
         3'h0:    gain_tenths = 8'h02;
         3'h1:    gain_tenths = 8'h04;
         3'h4:    gain_tenths = 8'h14;
         3'h7:    gain_tenths = 8'ha0;
         default: gain_tenths = 8'h00;
      endcase
   endfunction : gain_tenths

   function automatic slot_cfg_t cfg_from_words(input logic [15:0] w0,
                                                input logic [15:0] w1,
                                                input logic [15:0] w2);
      slot_cfg_t c;
      c.positive_input_select     = w0[15:12];
      c.negative_input_select     = w0[11:8];
      c.gain_code                 = w0[7:5];
      c.high_voltage_path_select  = w0[4];
      c.internal_signal_select    = w0[3:1];
      c.tempco_correction_disable = w0[0];
      c.calibration_set_select    = w1[15:12];
      c.alarm_threshold_select    = w1[11:8];
      c.data_rate_code            = w1[7:3];
      c.filter_type               = w1[2:0];
      c.preconversion_delay_code  = w2[15:10];
      c.normal_settling_option    = w2[9];
      c.filter_reset_option       = w2[8];
      c.chopping_enable           = w2[7];
      c.gain_tenths               = gain_tenths(w0[7:5]);
      case (w1[2:0])
         3'h0:    c.filter = FILT_FOURTH_ORDER_SINC;
         3'h1:    c.filter = FILT_FOURTH_ORDER_SINC_FIRST_ORDER_SINC;
         default: c.filter = FILT_OTHER;
      endcase
      return c;
   endfunction : cfg_from_words

endpackage : seq_pkg

// ==== verilog/spi_reg_port.sv ====
// serial register port: 24-bit frames, mode 0, msb first
// assumes pins are asynchronous and sclk half period is at least 4 sys_clk cycles
module spi_reg_port
   import seq_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        spi_sclk,
   input  wire logic        spi_cs_n,
   input  wire logic        spi_mosi,
   output logic             spi_miso_o,
   output logic             spi_miso_oe,
   output spi_req_t         req,
   output logic             req_valid,
   output logic [6:0]       rd_addr,
   input  wire logic [15:0] rd_data
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [2:0] sclk_r, cs_n_r;
   logic [1:0] mosi_r;
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         sclk_r <= 3'h0;
         cs_n_r <= 3'h7;
         mosi_r <= 2'h0;
      end
      else
      begin
         sclk_r <= {sclk_r[1:0], spi_sclk};
         cs_n_r <= {cs_n_r[1:0], spi_cs_n};
         mosi_r <= {mosi_r[0], spi_mosi};
      end
   end

   // ****************************************
   // frame shifter
   // ****************************************
   logic [22:0] sh_r, sh_nxt;
   logic [4:0]  cnt_r, cnt_nxt;
   logic [15:0] tx_r, tx_nxt;
   logic        pend_r, pend_nxt, miso_r, miso_nxt, vld_r, vld_nxt;
   logic [6:0]  addr_r, addr_nxt;
   spi_req_t    req_r, req_nxt;
   logic        rise, fall, active;
   logic [23:0] frame;

   always_comb
   begin
      rise     = sclk_r[1] & ~sclk_r[2];
      fall     = ~sclk_r[1] & sclk_r[2];
      active   = ~cs_n_r[1];
      frame    = {sh_r, mosi_r[1]};
      sh_nxt   = sh_r;
      cnt_nxt  = cnt_r;
      tx_nxt   = tx_r;
      pend_nxt = 1'b0;
      miso_nxt = miso_r;
      vld_nxt  = 1'b0;
      addr_nxt = addr_r;
      req_nxt  = req_r;
      if (!active)
      begin
         cnt_nxt  = 5'h00;
         tx_nxt   = 16'h0000;
         miso_nxt = 1'b0;
      end
      else
      begin
         if (pend_r)
            tx_nxt = rd_data;
         if (rise)
         begin
            sh_nxt  = frame[22:0];
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == 5'(SPI_CMD_BITS - 1))
            begin
               addr_nxt = frame[6:0];
               pend_nxt = frame[7];
            end
            if (cnt_r == 5'(SPI_FRAME_BITS - 1))
            begin
               cnt_nxt       = 5'h00;
               req_nxt.wr    = ~frame[23];
               req_nxt.addr  = frame[22:16];
               req_nxt.wdata = frame[15:0];
               vld_nxt       = ~frame[23];
            end
         end
         else if (fall)
         begin
            miso_nxt = tx_r[15];
            tx_nxt   = {tx_r[14:0], 1'b0};
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         sh_r   <= 23'h00_0000;
         cnt_r  <= 5'h00;
         tx_r   <= 16'h0000;
         pend_r <= 1'b0;
         miso_r <= 1'b0;
         vld_r  <= 1'b0;
         addr_r <= 7'h00;
         req_r  <= '0;
      end
      else
      begin
         sh_r   <= sh_nxt;
         cnt_r  <= cnt_nxt;
         tx_r   <= tx_nxt;
         pend_r <= pend_nxt;
         miso_r <= miso_nxt;
         vld_r  <= vld_nxt;
         addr_r <= addr_nxt;
         req_r  <= req_nxt;
      end
   end

   assign spi_miso_o  = miso_r;
   assign spi_miso_oe = ~cs_n_r[1];
   assign req         = req_r;
   assign req_valid   = vld_r;
   assign rd_addr     = addr_r;

endmodule : spi_reg_port
